// ===== core/context_bank_attr_regs.sv
// Context bank attribute register bank with Wishbone slave and decoded outputs of the selected bank
`timescale 1ns/1ps
module context_bank_attr_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Datapath query
  input wire logic [cb_attr_pkg::BANK_W-1:0] bank_sel_i,
  input wire logic [1:0] s1_share_i,
  // Decoded attributes of the selected bank
  output logic [1:0] ctx_type_o,
  output logic [7:0] fault_interrupt_index_o,
  output logic [1:0] write_alloc_hint_o,
  output logic [1:0] read_alloc_hint_o,
  output logic [1:0] barrier_share_upgrade_o,
  output logic [3:0] memory_attribute_value_o,
  output logic force_broadcast_o,
  output logic use_vm_tag_o,
  output logic use_address_space_tag_o,
  output logic [1:0] bypass_shareability_o,
  output logic [1:0] result_share_o,
  output logic [7:0] virtual_machine_tag_o,
  output logic [7:0] nested_stage2_bank_index_o,
  output logic invalid_context_fault_o,
  output logic reserved_hint_o
);
  logic [31:0] bank_r [cb_attr_pkg::NUM_BANKS];
  logic [31:0] bank_nxt [cb_attr_pkg::NUM_BANKS];
  logic [2:0] ctrl_r;
  logic [2:0] ctrl_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt, err_r, err_nxt;
  logic req;
  logic hit_bank, hit_ctrl;
  logic [cb_attr_pkg::BANK_W-1:0] widx;
  logic [31:0] bmask;
  logic [31:0] wmask;

  assign req = cyc_i & stb_i & ~ack_r & ~err_r;
  assign widx = adr_i[cb_attr_pkg::BANK_W+1:2];
  assign hit_bank = (adr_i[31:cb_attr_pkg::BANK_W+2] == cb_attr_pkg::BANK_BASE[31:cb_attr_pkg::BANK_W+2])
                    && (adr_i[1:0] == 2'h0);
  assign hit_ctrl = (adr_i == cb_attr_pkg::CTRL_ADDR);
  assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // Writable bits: unimplemented index bits stay zero, absent barrier upgrade bits keep their stored value
  always_comb begin
    wmask = cb_attr_pkg::WMASK_BASE | cb_attr_pkg::IRQ_MASK;
    if (!ctrl_r[cb_attr_pkg::CTRL_BSU_BIT]) begin
      wmask = wmask & ~cb_attr_pkg::BSU_MASK;
    end
  end

  // Nested index upper bits share bits 15:10 with other layouts, so only type 11 trims them
  function automatic logic [31:0] trim(input logic [31:0] v);
    logic [31:0] t;
    t = v;
    if (v[cb_attr_pkg::TYPE_LSB +: 2] == 2'(cb_attr_pkg::CTX_NESTED)) begin
      t[cb_attr_pkg::NEST_LSB + cb_attr_pkg::NEST_IMPL_W +: 8 - cb_attr_pkg::NEST_IMPL_W] = '0;
    end
    return t;
  endfunction

  always_comb begin
    bank_nxt = bank_r;
    ctrl_nxt = ctrl_r;
    dat_nxt = dat_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    if (req) begin
      if (hit_bank) begin
        ack_nxt = 1'b1;
        // Stored barrier bits survive a support switch-off but must read zero meanwhile
        dat_nxt = trim(bank_r[widx]) & wmask;
        if (we_i) begin
          bank_nxt[widx] = trim((bank_r[widx] & ~(bmask & wmask)) | (dat_i & bmask & wmask));
        end
      end else if (hit_ctrl) begin
        ack_nxt = 1'b1;
        dat_nxt = {29'h0000_0000, ctrl_r};
        if (we_i && sel_i[0]) begin
          ctrl_nxt = dat_i[2:0];
        end
      end else begin
        err_nxt = 1'b1;
        dat_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < cb_attr_pkg::NUM_BANKS; i++) begin
        bank_r[i] <= cb_attr_pkg::RESET_VAL;
      end
      ctrl_r <= 3'h0;
      dat_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      bank_r <= bank_nxt;
      ctrl_r <= ctrl_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign err_o = err_r;

  // Decode of the selected bank, registered so every output leaves a flip-flop
  logic [31:0] cur;
  logic [1:0] ty;
  logic [1:0] s2sh;
  logic [1:0] ctx_type_nxt, wa_nxt, ra_nxt, bsu_nxt, bpsh_nxt, rsh_nxt;
  logic [7:0] irq_nxt, vmt_nxt, nest_nxt;
  logic [3:0] mattr_nxt;
  logic fb_nxt, uvm_nxt, uas_nxt, fault_nxt, rsvd_nxt;

  always_comb begin
    cur = trim(bank_r[bank_sel_i]);
    ty = cur[cb_attr_pkg::TYPE_LSB +: 2];
    irq_nxt = cur[cb_attr_pkg::IRQ_LSB +: 8];
    vmt_nxt = cur[cb_attr_pkg::VMT_LSB +: 8];
    if (ctrl_r[cb_attr_pkg::CTRL_SEC_BIT]) begin
      vmt_nxt = 8'h00;
    end
    wa_nxt = 2'h0;
    ra_nxt = 2'h0;
    bsu_nxt = 2'h0;
    mattr_nxt = 4'h0;
    fb_nxt = 1'b0;
    uvm_nxt = 1'b0;
    uas_nxt = 1'b0;
    bpsh_nxt = 2'h0;
    nest_nxt = 8'h00;
    fault_nxt = 1'b0;
    rsvd_nxt = 1'b0;
    s2sh = cb_attr_pkg::SH_NONE;
    case (ty)
      2'(cb_attr_pkg::CTX_S1_BYPASS): begin
        wa_nxt = cur[cb_attr_pkg::WA_LSB +: 2];
        ra_nxt = cur[cb_attr_pkg::RA_LSB +: 2];
        if (ctrl_r[cb_attr_pkg::CTRL_BSU_BIT]) begin
          bsu_nxt = cur[cb_attr_pkg::BSU_LSB +: 2];
        end
        mattr_nxt = cur[cb_attr_pkg::MATTR_LSB +: 4];
        fb_nxt = cur[cb_attr_pkg::FB_BIT];
        uvm_nxt = ~cur[cb_attr_pkg::HYPERVISOR_CONTEXT_BIT_BIT];
        uas_nxt = ~cur[cb_attr_pkg::HYPERVISOR_CONTEXT_BIT_BIT];
        bpsh_nxt = cur[cb_attr_pkg::BPSH_LSB +: 2];
        rsvd_nxt = (wa_nxt == cb_attr_pkg::HINT_RSVD) || (ra_nxt == cb_attr_pkg::HINT_RSVD)
                   || (bpsh_nxt == 2'h0);
        case (bpsh_nxt)
          cb_attr_pkg::BP_OUTER: s2sh = cb_attr_pkg::SH_OUTER;
          cb_attr_pkg::BP_INNER: s2sh = cb_attr_pkg::SH_INNER;
          default: s2sh = cb_attr_pkg::SH_NONE;
        endcase
      end
      2'(cb_attr_pkg::CTX_S1_FAULT): begin
        fault_nxt = 1'b1;
      end
      2'(cb_attr_pkg::CTX_NESTED): begin
        nest_nxt = cur[cb_attr_pkg::NEST_LSB +: 8];
        fault_nxt = ~ctrl_r[cb_attr_pkg::CTRL_NTS_BIT];
      end
      default: begin
      end
    endcase
    rsh_nxt = (s1_share_i > s2sh) ? s1_share_i : s2sh;
    ctx_type_nxt = ty;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctx_type_o <= 2'h0;
      fault_interrupt_index_o <= 8'h00;
      write_alloc_hint_o <= 2'h0;
      read_alloc_hint_o <= 2'h0;
      barrier_share_upgrade_o <= 2'h0;
      memory_attribute_value_o <= 4'h0;
      force_broadcast_o <= 1'b0;
      use_vm_tag_o <= 1'b0;
      use_address_space_tag_o <= 1'b0;
      bypass_shareability_o <= 2'h0;
      result_share_o <= 2'h0;
      virtual_machine_tag_o <= 8'h00;
      nested_stage2_bank_index_o <= 8'h00;
      invalid_context_fault_o <= 1'b0;
      reserved_hint_o <= 1'b0;
    end else begin
      ctx_type_o <= ctx_type_nxt;
      fault_interrupt_index_o <= irq_nxt;
      write_alloc_hint_o <= wa_nxt;
      read_alloc_hint_o <= ra_nxt;
      barrier_share_upgrade_o <= bsu_nxt;
      memory_attribute_value_o <= mattr_nxt;
      force_broadcast_o <= fb_nxt;
      use_vm_tag_o <= uvm_nxt;
      use_address_space_tag_o <= uas_nxt;
      bypass_shareability_o <= bpsh_nxt;
      result_share_o <= rsh_nxt;
      virtual_machine_tag_o <= vmt_nxt;
      nested_stage2_bank_index_o <= nest_nxt;
      invalid_context_fault_o <= fault_nxt;
      reserved_hint_o <= rsvd_nxt;
    end
  end

  a_fault_type: assert property (@(posedge clk_i) disable iff (rst_i)
    (trim(bank_r[bank_sel_i]) >> cb_attr_pkg::TYPE_LSB) % 4 == 2 |=> invalid_context_fault_o)
    else $error("Fault layout did not raise invalid context fault");
  a_nested_nts: assert property (@(posedge clk_i) disable iff (rst_i)
    ctx_type_o == 2'h3 |-> invalid_context_fault_o == ~$past(ctrl_r[0]))
    else $error("Nested fault does not follow nested support");
  a_irq_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_interrupt_index_o[7:4] == 4'h0)
    else $error("Unimplemented interrupt index bits not zero");
  a_bsu_raz: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(ctrl_r[cb_attr_pkg::CTRL_BSU_BIT]) |-> barrier_share_upgrade_o == 2'h0)
    else $error("Barrier upgrade visible while unsupported");
  a_offtype_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ctx_type_o != 2'h1 |-> write_alloc_hint_o == 2'h0 && memory_attribute_value_o == 4'h0 && !force_broadcast_o)
    else $error("Bypass fields leak into another layout");
  a_hyp_tags: assert property (@(posedge clk_i) disable iff (rst_i)
    ctx_type_o == 2'h1 |-> use_vm_tag_o == use_address_space_tag_o)
    else $error("Tag usage flags disagree");
  a_share_wide: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(s1_share_i) == 2'h2 |-> result_share_o == 2'h2)
    else $error("Outer stage-1 shareability not kept");
  a_nest_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ctx_type_o != 2'h3 |-> nested_stage2_bank_index_o == 8'h00)
    else $error("Nested index outside nested layout");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("Acknowledge held longer than one cycle");
endmodule // context_bank_attr_regs

// ===== include/cb_attr_pkg.sv
// Package with register map, field layout and encodings of the context bank attribute registers
package cb_attr_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int IRQ_IMPL_W = 4;
  localparam int NEST_IMPL_W = 2;
  localparam logic [31:0] BANK_BASE = 32'h0000_0000;
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0100;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  localparam int IRQ_LSB = 24;
  localparam int WA_LSB = 22;
  localparam int RA_LSB = 20;
  localparam int BSU_LSB = 18;
  localparam int TYPE_LSB = 16;
  localparam int MATTR_LSB = 12;
  localparam int FB_BIT = 11;
  localparam int HYPERVISOR_CONTEXT_BIT_BIT = 10;
  localparam int BPSH_LSB = 8;
  localparam int NEST_LSB = 8;
  localparam int VMT_LSB = 0;
  localparam logic [31:0] WMASK_BASE = 32'h00FF_FFFF;
  localparam logic [31:0] BSU_MASK = 32'h000C_0000;
  localparam logic [31:0] IRQ_MASK = 32'h0F00_0000;
  localparam logic [31:0] NEST_WR_MASK = 32'h0000_0300;
  localparam logic [31:0] NEST_HOLE = 32'h0000_FC00;
  localparam int CTRL_NTS_BIT = 0;
  localparam int CTRL_BSU_BIT = 1;
  localparam int CTRL_SEC_BIT = 2;
  typedef enum logic [1:0] {CTX_S2_ONLY, CTX_S1_BYPASS, CTX_S1_FAULT, CTX_NESTED} ctx_type_t;
  localparam logic [1:0] SH_NONE = 2'h0;
  localparam logic [1:0] SH_INNER = 2'h1;
  localparam logic [1:0] SH_OUTER = 2'h2;
  localparam logic [1:0] BP_OUTER = 2'h1;
  localparam logic [1:0] BP_INNER = 2'h2;
  localparam logic [1:0] BP_NONSH = 2'h3;
  localparam logic [1:0] HINT_RSVD = 2'h1;
endpackage

// ===== verification/tb_top.sv
// Self-checking bench for the context bank attribute register bank
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("FAIL %0t mismatch %h vs %h", $time, (a), (b)); end end
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [31:0] adr_i = 32'h0000_0000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [cb_attr_pkg::BANK_W-1:0] bank_sel_i = '0;
  logic [1:0] s1_share_i = 2'h0;
  logic [31:0] dat_o;
  logic ack_o, err_o, force_broadcast_o, use_vm_tag_o, use_address_space_tag_o, invalid_context_fault_o;
  logic reserved_hint_o;
  logic [1:0] ctx_type_o, write_alloc_hint_o, read_alloc_hint_o, barrier_share_upgrade_o;
  logic [1:0] bypass_shareability_o, result_share_o;
  logic [3:0] memory_attribute_value_o;
  logic [7:0] fault_interrupt_index_o, virtual_machine_tag_o, nested_stage2_bank_index_o;
  int errors = 0;
  int check_count = 0;
  localparam logic [31:0] CTRL = cb_attr_pkg::CTRL_ADDR;

  context_bank_attr_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .bank_sel_i(bank_sel_i), .s1_share_i(s1_share_i), .ctx_type_o(ctx_type_o),
    .fault_interrupt_index_o(fault_interrupt_index_o), .write_alloc_hint_o(write_alloc_hint_o),
    .read_alloc_hint_o(read_alloc_hint_o), .barrier_share_upgrade_o(barrier_share_upgrade_o),
    .memory_attribute_value_o(memory_attribute_value_o), .force_broadcast_o(force_broadcast_o),
    .use_vm_tag_o(use_vm_tag_o), .use_address_space_tag_o(use_address_space_tag_o),
    .bypass_shareability_o(bypass_shareability_o), .result_share_o(result_share_o),
    .virtual_machine_tag_o(virtual_machine_tag_o), .nested_stage2_bank_index_o(nested_stage2_bank_index_o),
    .invalid_context_fault_o(invalid_context_fault_o), .reserved_hint_o(reserved_hint_o));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Classic cycle: request held until ack or err is sampled at a rising edge
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin
      errors++;
      $display("FAIL %0t bus timeout", $time);
      end_of_test;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    logic e;
    wb(1'b1, a, d, s, q, e);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    logic e;
    wb(1'b0, a, 32'h0000_0000, 4'hF, q, e);
  endtask

  // Decoded outputs are registered, so give them two edges to settle
  task automatic look(input logic [1:0] b, input logic [1:0] s);
    @(posedge clk_i);
    bank_sel_i <= b;
    s1_share_i <= s;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rd(32'h0000_0004, q);
    `CHK(q, 32'h0000_0000)
    wb(1'b1, 32'h0000_0200, 32'hFFFF_FFFF, 4'hF, q, e);
    `CHK(e, 1'b1)
    look(2'h0, 2'h0);
    `CHK(ctx_type_o, 2'h0)
  endtask

  task automatic t_bypass;
    logic [31:0] q;
    wr(CTRL, 32'h0000_0003, 4'hF);
    wr(32'h0000_0004, 32'hA5B5_993C, 4'hF);
    rd(32'h0000_0004, q);
    `CHK(q, 32'h05B5_993C)
    look(2'h1, 2'h1);
    `CHK(ctx_type_o, 2'h1)
    `CHK(fault_interrupt_index_o, 8'h05)
    `CHK(write_alloc_hint_o, 2'h2)
    `CHK(read_alloc_hint_o, 2'h3)
    `CHK(barrier_share_upgrade_o, 2'h1)
    `CHK(memory_attribute_value_o, 4'h9)
    `CHK(force_broadcast_o, 1'b1)
    `CHK(use_vm_tag_o & use_address_space_tag_o, 1'b1)
    `CHK(bypass_shareability_o, 2'h1)
    `CHK(result_share_o, 2'h2)
    `CHK(virtual_machine_tag_o, 8'h3C)
    `CHK(nested_stage2_bank_index_o | {7'h00, invalid_context_fault_o}, 8'h00)
    wr(32'h0000_0004, 32'h0000_0077, 4'h1);
    rd(32'h0000_0004, q);
    `CHK(q, 32'h05B5_9977)
  endtask

  task automatic t_nobsu;
    logic [31:0] q;
    wr(CTRL, 32'h0000_0004, 4'hF);
    wr(32'h0000_0008, 32'hA5B5_943C, 4'hF);
    rd(32'h0000_0008, q);
    `CHK(q, 32'h05B1_943C)
    rd(32'h0000_0004, q);
    `CHK(q, 32'h05B1_9977)
    look(2'h2, 2'h0);
    `CHK(use_vm_tag_o | use_address_space_tag_o, 1'b0)
    `CHK(force_broadcast_o, 1'b0)
    `CHK(reserved_hint_o, 1'b1)
    `CHK(virtual_machine_tag_o, 8'h00)
    `CHK(result_share_o, 2'h0)
  endtask

  task automatic t_fault;
    logic [31:0] q;
    wr(32'h0000_000C, 32'h0302_FF11, 4'hF);
    rd(32'h0000_000C, q);
    `CHK(q, 32'h0302_FF11)
    look(2'h3, 2'h2);
    `CHK(ctx_type_o, 2'h2)
    `CHK(invalid_context_fault_o, 1'b1)
    `CHK(fault_interrupt_index_o, 8'h03)
    `CHK(memory_attribute_value_o, 4'h0)
    `CHK(result_share_o, 2'h2)
  endtask

  task automatic t_nested;
    logic [31:0] q;
    wr(CTRL, 32'h0000_0000, 4'hF);
    // The nested walk may only target a stage-2-only bank, so bank 3 goes back to type 00
    wr(32'h0000_000C, 32'h0000_0000, 4'hF);
    wr(32'h0000_0000, 32'h0003_FF22, 4'hF);
    rd(32'h0000_0000, q);
    `CHK(q, 32'h0003_0322)
    look(2'h0, 2'h0);
    `CHK(ctx_type_o, 2'h3)
    `CHK(nested_stage2_bank_index_o, 8'h03)
    `CHK(virtual_machine_tag_o, 8'h22)
    `CHK(invalid_context_fault_o, 1'b1)
    wr(CTRL, 32'h0000_0001, 4'hF);
    look(2'h0, 2'h0);
    `CHK(invalid_context_fault_o, 1'b0)
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_bypass;
    t_nobsu;
    t_fault;
    t_nested;
    end_of_test;
  end
endmodule // tb_top
